//--- swm_pkg.sv
/*
 * package for the single-wire bus master: register map, field positions,
 * reset values, slot timing and shared types.
 * assumes a 100 MHz system clock and a divided 1 us bus timing tick.
 */
package swm_pkg;

   // register bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] REG_CFG  = 8'h00;
   localparam logic [ADDR_W-1:0] REG_DIV  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DATA = 8'h0C;

   // field positions
   localparam int CFG_BB_EN_BIT   = 0;
   localparam int CFG_TXFULL_BIT  = 1;
   localparam int CTRL_LAUNCH_BIT = 0;
   localparam int CTRL_SRA_BIT    = 1;
   localparam int CTRL_BBOE_BIT   = 2;
   localparam int CTRL_SENSE_BIT  = 3;
   localparam int CTRL_PD_BIT     = 5;

   // reset values
   localparam logic [BYTE_W-1:0] DIV_RST  = 8'h00;
   localparam logic [BYTE_W-1:0] DATA_RST = 8'h00;
   localparam logic LINE_IDLE = 1'b1;

   // timing in microseconds, counts in 1 us ticks
   localparam int TICK_US        = 1;
   localparam int T_RST_LOW_US   = 480;
   localparam int T_RST_REC_US   = 480;
   localparam int T_PD_SAMPLE_US = 70;
   localparam int T_W1_LOW_US    = 5;
   localparam int T_SAMPLE_US    = 15;
   localparam int T_W0_LOW_US    = 60;
   localparam int T_REC_US       = 7;
   localparam logic [9:0] RST_LOW_TICKS = 10'(T_RST_LOW_US / TICK_US);
   localparam logic [9:0] RST_REC_TICKS = 10'(T_RST_REC_US / TICK_US);
   localparam logic [9:0] PD_TICKS      = 10'(T_PD_SAMPLE_US / TICK_US);
   localparam logic [9:0] W1_LOW_TICKS  = 10'(T_W1_LOW_US / TICK_US);
   localparam logic [9:0] SAMPLE_TICKS  = 10'(T_SAMPLE_US / TICK_US);
   localparam logic [9:0] W0_LOW_TICKS  = 10'(T_W0_LOW_US / TICK_US);
   localparam logic [9:0] SLOT_TICKS    = 10'((T_W0_LOW_US + T_REC_US) / TICK_US);

   // software-held control bits, in their register order
   typedef struct packed {
      logic bb_oe;
      logic sra;
      logic launch;
   } swm_ctrl_t;

   // open-drain pin drive towards the pad
   typedef struct packed {
      logic level;
      logic oe;
   } swm_pin_t;

endpackage

//--- swm_sync.sv
/*
 * two flip-flop synchroniser for the bus line input.
 * assumes the input is asynchronous to sys_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module swm_sync (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // line
   input wire logic async_i,
   output logic sync_o
);
   import swm_pkg::*;

   logic meta_q;
   logic sync_q;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         meta_q <= LINE_IDLE;
         sync_q <= LINE_IDLE;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // swm_sync
`default_nettype wire

//--- swm_buf2.sv
/*
 * two-entry byte buffer with valid/ready on both sides.
 * assumes both sides on sys_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module swm_buf2 (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [swm_pkg::BYTE_W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [swm_pkg::BYTE_W-1:0] out_data_o
);
   import swm_pkg::*;

   logic [BYTE_W-1:0] mem_q [2];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   wire push_w = in_valid_i && in_ready_o;
   wire pop_w = out_valid_o && out_ready_i;

   assign in_ready_o = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o = mem_q[rd_q];

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         mem_q[0] <= DATA_RST;
         mem_q[1] <= DATA_RST;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push_w) begin
            mem_q[wr_q] <= in_data_i;
            wr_q <= ~wr_q;
         end
         if (pop_w) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push_w} - {1'b0, pop_w};
      end
   end
endmodule // swm_buf2
`default_nettype wire

//--- swm_master.sv
/*
 * single-wire bus master: control/status bits, byte buffer, reset and
 * data slot engine, search accelerator, bit-bang drive.
 * assumes an external pull-up on the line and a plain register port.
 */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module swm_master (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [swm_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [swm_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [swm_pkg::DATA_W-1:0] reg_rdata_o,
   // bus line
   input wire logic bus_line_pin_i,
   output logic bus_line_pin_o,
   output logic bus_line_pin_oe_o
);
   import swm_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_SLOT} swm_state_t;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // registers
   swm_ctrl_t ctrl_q, ctrl_d;
   swm_state_t st_q, st_d;
   swm_pin_t pin_q, pin_d;
   logic bb_en_q, bb_en_d;
   logic [BYTE_W-1:0] div_q, div_d;
   logic [BYTE_W-1:0] div_cnt_q, div_cnt_d;
   logic [9:0] us_q, us_d;
   logic [2:0] bit_q, bit_d;
   logic [1:0] phase_q, phase_d;
   logic [BYTE_W-1:0] tx_q, tx_d;
   logic [BYTE_W-1:0] rx_q, rx_d;
   logic [BYTE_W-1:0] rx_last_q, rx_last_d;
   logic smp_q, smp_d;
   logic id_q, id_d;
   logic cmp_q, cmp_d;
   logic sra_run_q, sra_run_d;
   logic pd_q, pd_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;

   // line sense
   logic sense_w;
   swm_sync u_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .async_i(bus_line_pin_i),
      .sync_o(sense_w)
   );

   // register decode
   wire wr_cfg_w = reg_we_i && hit(reg_addr_i, REG_CFG);
   wire wr_div_w = reg_we_i && hit(reg_addr_i, REG_DIV);
   wire wr_ctrl_w = reg_we_i && hit(reg_addr_i, REG_CTRL);
   wire wr_data_w = reg_we_i && hit(reg_addr_i, REG_DATA);

   // transmit byte buffer
   logic buf_in_ready_w;
   logic buf_out_valid_w;
   logic [BYTE_W-1:0] buf_out_data_w;
   wire start_rst_w = (st_q == ST_IDLE) && ctrl_q.launch;
   wire buf_pop_w = (st_q == ST_IDLE) && !ctrl_q.launch && buf_out_valid_w;
   swm_buf2 u_buf (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_data_w),
      .in_ready_o(buf_in_ready_w),
      .in_data_i(reg_wdata_i[BYTE_W-1:0]),
      .out_valid_o(buf_out_valid_w),
      .out_ready_i(buf_pop_w),
      .out_data_o(buf_out_data_w)
   );

   // timing tick from divisor, 0 stops it
   wire tick_w = (div_q != DIV_RST) && (div_cnt_q == div_q - 8'h01);
   assign div_cnt_d = (tick_w || div_q == DIV_RST) ? 8'h00 : div_cnt_q + 8'h01;

   // slot write value: search triplet or plain lsb
   wire dir_w = (id_q != cmp_q) ? id_q : (id_q ? 1'b1 : tx_q[0]);
   wire slot_val_w = sra_run_q ? ((phase_q == 2'h2) ? dir_w : 1'b1) : tx_q[0];
   wire [9:0] low_len_w = slot_val_w ? W1_LOW_TICKS : W0_LOW_TICKS;
   wire eng_drv_w = (st_q == ST_RST_LOW) || ((st_q == ST_SLOT) && (us_q < low_len_w));
   wire slot_end_w = (st_q == ST_SLOT) && tick_w && (us_q == SLOT_TICKS - 10'h001);
   wire bit_done_w = slot_end_w && (!sra_run_q || phase_q == 2'h2);
   wire rx_bit_w = sra_run_q ? dir_w : smp_q;
   wire byte_done_w = bit_done_w && (bit_q == 3'h7);
   wire rst_done_w = (st_q == ST_RST_WAIT) && tick_w && (us_q == RST_REC_TICKS - 10'h001);
   wire pd_hit_w = (st_q == ST_RST_WAIT) && tick_w && (us_q == PD_TICKS) && !sense_w;
   wire [BYTE_W-1:0] rx_fin_w = {rx_bit_w, rx_q[BYTE_W-1:1]};

   // software state
   assign bb_en_d = wr_cfg_w ? reg_wdata_i[CFG_BB_EN_BIT] : bb_en_q;
   assign div_d = wr_div_w ? reg_wdata_i[BYTE_W-1:0] : div_q;
   assign ctrl_d.bb_oe = wr_ctrl_w ? reg_wdata_i[CTRL_BBOE_BIT] : ctrl_q.bb_oe;
   assign ctrl_d.sra = wr_ctrl_w ? reg_wdata_i[CTRL_SRA_BIT] : ctrl_q.sra;
   // set wins over hardware clear
   assign ctrl_d.launch = (wr_ctrl_w && reg_wdata_i[CTRL_LAUNCH_BIT])
                          || (ctrl_q.launch && !rst_done_w);
   assign pd_d = start_rst_w ? 1'b0 : (pd_q || pd_hit_w);
   assign rx_last_d = byte_done_w ? rx_fin_w : rx_last_q;

   // pin drive
   assign pin_d.level = 1'b0;
   assign pin_d.oe = bb_en_q ? ctrl_q.bb_oe : eng_drv_w;
   assign bus_line_pin_o = pin_q.level;
   assign bus_line_pin_oe_o = pin_q.oe;

   // read mux
   wire [DATA_W-1:0] cfg_rd_w = DATA_W'({!buf_in_ready_w, bb_en_q});
   wire [DATA_W-1:0] ctrl_rd_w = DATA_W'({pd_q, 1'b0, sense_w, ctrl_q});
   wire [DATA_W-1:0] data_rd_w = DATA_W'(rx_last_q);
   assign rdata_d = !reg_re_i ? '0 :
                    hit(reg_addr_i, REG_CFG) ? cfg_rd_w :
                    hit(reg_addr_i, REG_DIV) ? DATA_W'(div_q) :
                    hit(reg_addr_i, REG_CTRL) ? ctrl_rd_w :
                    hit(reg_addr_i, REG_DATA) ? data_rd_w : '0;
   assign reg_rdata_o = rdata_q;

   // engine
   always_comb begin
      st_d = st_q;
      us_d = us_q;
      bit_d = bit_q;
      phase_d = phase_q;
      tx_d = tx_q;
      rx_d = rx_q;
      smp_d = smp_q;
      id_d = id_q;
      cmp_d = cmp_q;
      sra_run_d = sra_run_q;
      unique case (st_q)
         ST_IDLE: begin
            us_d = 10'h000;
            if (start_rst_w) begin
               st_d = ST_RST_LOW;
            end else if (buf_pop_w) begin
               st_d = ST_SLOT;
               tx_d = buf_out_data_w;
               bit_d = 3'h0;
               phase_d = 2'h0;
               sra_run_d = ctrl_q.sra;
            end
         end
         ST_RST_LOW: begin
            if (tick_w) begin
               us_d = us_q + 10'h001;
               if (us_q == RST_LOW_TICKS - 10'h001) begin
                  st_d = ST_RST_WAIT;
                  us_d = 10'h000;
               end
            end
         end
         ST_RST_WAIT: begin
            if (tick_w) begin
               us_d = us_q + 10'h001;
               if (rst_done_w) begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_SLOT: begin
            if (tick_w) begin
               us_d = us_q + 10'h001;
               if (us_q == SAMPLE_TICKS) begin
                  smp_d = sense_w;
               end
            end
            if (slot_end_w) begin
               us_d = 10'h000;
               phase_d = phase_q + 2'h1;
               if (sra_run_q && phase_q == 2'h0) begin
                  id_d = smp_q;
               end
               if (sra_run_q && phase_q == 2'h1) begin
                  cmp_d = smp_q;
               end
            end
            if (bit_done_w) begin
               phase_d = 2'h0;
               rx_d = rx_fin_w;
               tx_d = {1'b0, tx_q[BYTE_W-1:1]};
               bit_d = bit_q + 3'h1;
               if (byte_done_w) begin
                  st_d = ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ctrl_q <= '0;
         bb_en_q <= 1'b0;
         div_q <= DIV_RST;
         div_cnt_q <= 8'h00;
         pd_q <= 1'b0;
         rx_last_q <= DATA_RST;
         pin_q <= '0;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         bb_en_q <= bb_en_d;
         div_q <= div_d;
         div_cnt_q <= div_cnt_d;
         pd_q <= pd_d;
         rx_last_q <= rx_last_d;
         pin_q <= pin_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         st_q <= ST_IDLE;
         us_q <= 10'h000;
         bit_q <= 3'h0;
         phase_q <= 2'h0;
         tx_q <= DATA_RST;
         rx_q <= DATA_RST;
         smp_q <= LINE_IDLE;
         id_q <= 1'b0;
         cmp_q <= 1'b0;
         sra_run_q <= 1'b0;
      end else begin
         st_q <= st_d;
         us_q <= us_d;
         bit_q <= bit_d;
         phase_q <= phase_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         smp_q <= smp_d;
         id_q <= id_d;
         cmp_q <= cmp_d;
         sra_run_q <= sra_run_d;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_rst_end;
      (st_q == ST_RST_WAIT) ##1 (st_q == ST_IDLE);
   endsequence

   a_sense_follows_pin: assert property (
      $past(resetn_i, 2) && $past(resetn_i) |-> sense_w == $past(bus_line_pin_i, 2))
      else $error("line sense does not follow pin");
   a_bitbang_pin_drive: assert property (
      bb_en_q && $stable(ctrl_q.bb_oe) && $stable(bb_en_q) |=> bus_line_pin_oe_o == $past(ctrl_q.bb_oe))
      else $error("bit-bang drive wrong");
   a_search_read_slots: assert property (
      (st_q == ST_SLOT) && sra_run_q && (phase_q != 2'h2) && !bb_en_q && (us_q >= W1_LOW_TICKS)
      |=> !bus_line_pin_oe_o)
      else $error("search read slot not released early");
   a_launch_starts_reset: assert property (
      (st_q == ST_IDLE) && ctrl_q.launch && !bb_en_q
      |=> (st_q == ST_RST_LOW) ##1 bus_line_pin_oe_o)
      else $error("reset sequence not started");
   a_launch_hw_clear: assert property (
      $fell(ctrl_q.launch) |-> $past(st_q == ST_RST_WAIT) && (st_q == ST_IDLE))
      else $error("launch bit cleared outside sequence end");
   a_launch_clear_end: assert property (
      s_rst_end |-> !ctrl_q.launch || $past(wr_ctrl_w && reg_wdata_i[CTRL_LAUNCH_BIT]))
      else $error("launch bit not cleared at sequence end");
   a_write_starts_cycle: assert property (
      wr_data_w && buf_in_ready_w && (st_q == ST_IDLE) && !ctrl_q.launch && !buf_out_valid_w
      |=> buf_out_valid_w ##1 (st_q == ST_SLOT) && (tx_q == $past(reg_wdata_i[BYTE_W-1:0], 2)))
      else $error("byte write did not start a cycle");
   a_read_last_byte: assert property (
      byte_done_w |=> (rx_last_q == $past(rx_fin_w)) && (st_q == ST_IDLE))
      else $error("received byte not returned");
   a_read_data_idle: assert property (
      !$past(reg_re_i) |-> reg_rdata_o == '0)
      else $error("read data not zero outside read cycle");
   a_presence_sets_flag: assert property (
      pd_hit_w |=> pd_q [*2] or (pd_q ##1 (st_q != ST_IDLE)))
      else $error("presence flag not set");
   a_slot_lsb_first: assert property (
      buf_pop_w && !ctrl_q.sra |=> (tx_q[0] == $past(buf_out_data_w[0])) && (st_q == ST_SLOT))
      else $error("first slot not lsb");
   a_slot_length: assert property (
      (st_q == ST_SLOT) |-> us_q < SLOT_TICKS)
      else $error("slot longer than its period");
endmodule // swm_master
`default_nettype wire

//--- swm_slave_model.sv
/*
 * behavioural slave on the open-drain line: answers a bus reset with a
 * presence pulse, sends send_byte_i lsb first, records the bits it sees.
 * assumes a 1 us tick of one sys_clk_i cycle and a resolved line at line_i.
 */
`timescale 1ns/100ps
`default_nettype none
module swm_slave_model (
   // clock
   input wire logic sys_clk_i,
   // line
   input wire logic line_i,
   output logic pull_o,
   // scenario control and observation
   input wire logic present_i,
   input wire logic [7:0] send_byte_i,
   output logic [7:0] got_byte_o,
   output logic [15:0] nbytes_o
);
   logic line_q;
   logic [2:0] idx;
   int low_cnt, since_fall, wait_cnt, pull_cnt;
   initial begin
      line_q = 1'b1;
      idx = 3'h0;
      low_cnt = 0;
      since_fall = 999;
      wait_cnt = 0;
      pull_cnt = 0;
      got_byte_o = 8'h00;
      nbytes_o = 16'h0000;
   end
   assign pull_o = (pull_cnt > 0);
   always @(posedge sys_clk_i) begin
      line_q <= line_i;
      low_cnt <= line_i ? 0 : low_cnt + 1;
      since_fall <= since_fall + 1;
      if (pull_cnt > 0) pull_cnt <= pull_cnt - 1;
      if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      // reset pulse over: presence pulse after a short wait
      if (line_i && !line_q && low_cnt >= 400) begin
         wait_cnt <= 15;
         idx <= 3'h0;
      end
      if (wait_cnt == 1 && present_i) pull_cnt <= 100;
      // slot start by the master: hold low to send a 0
      if (!line_i && line_q && pull_cnt == 0) begin
         since_fall <= 0;
         if (!send_byte_i[idx] && present_i) pull_cnt <= 30;
      end
      if (since_fall == 14) begin
         got_byte_o <= {line_i, got_byte_o[7:1]};
         idx <= idx + 3'h1;
         if (idx == 3'h7) nbytes_o <= nbytes_o + 16'h0001;
      end
   end
endmodule // swm_slave_model
`default_nettype wire

//--- tb_single_wire_master_ctrl_data.sv
/*
 * self-checking testbench for swm_master with one slave model.
 * assumes the register map of swm_pkg and a 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_single_wire_master_ctrl_data;
   import swm_pkg::*;
   logic sys_clk_i, resetn_i, reg_we_i, reg_re_i, present, pull, pin_o, pin_oe;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, v;
   logic [7:0] send_byte, got_byte;
   logic [15:0] nbytes, n0;
   wire logic line = !(pin_oe | pull);
   int mismatches = 0;
   int cmp_count = 0;
   swm_master swm_master_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .bus_line_pin_i(line), .bus_line_pin_o(pin_o), .bus_line_pin_oe_o(pin_oe));
   swm_slave_model swm_slave_model_inst (.sys_clk_i(sys_clk_i), .line_i(line), .pull_o(pull),
      .present_i(present), .send_byte_i(send_byte), .got_byte_o(got_byte), .nbytes_o(nbytes));
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_re_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic wait_launch_clear();
      int i;
      for (i = 0; i < 1000; i++) begin
         rd(REG_CTRL, v);
         if (v[CTRL_LAUNCH_BIT] === 1'b0) break;
      end
      if (i == 1000) begin
         mismatches++;
         stop_test();
      end
   endtask
   task automatic t_reset_values();
      rd(REG_DATA, v);
      check("data reset", v, 32'h0000_0000);
      rd(REG_CTRL, v);
      check("ctrl reset", v, 32'h0000_0008);
      rd(REG_DIV, v);
      check("div reset", v, 32'h0000_0000);
      rd(8'h10, v);
      check("unmapped", v, 32'h0000_0000);
      $display("test reset_values done");
   endtask
   task automatic t_bit_bang();
      wr(REG_CFG, 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0004);
      repeat (4) @(posedge sys_clk_i);
      check("oe driven", {31'h0, pin_oe}, 32'h1);
      check("pin value", {31'h0, pin_o}, 32'h0);
      rd(REG_CTRL, v);
      check("sense low", v, 32'h0000_0004);
      wr(REG_CTRL, 32'h0000_0000);
      repeat (4) @(posedge sys_clk_i);
      check("oe released", {31'h0, pin_oe}, 32'h0);
      rd(REG_CTRL, v);
      check("sense high", v, 32'h0000_0008);
      wr(REG_CFG, 32'h0000_0000);
      $display("test bit_bang done");
   endtask
   task automatic t_search_bit();
      wr(REG_CTRL, 32'h0000_0002);
      rd(REG_CTRL, v);
      check("search on", v, 32'h0000_000A);
      wr(REG_CTRL, 32'h0000_0000);
      rd(REG_CTRL, v);
      check("search off", v, 32'h0000_0008);
      $display("test search_bit done");
   endtask
   task automatic t_bus_reset(input logic pres);
      present <= pres;
      wr(REG_CTRL, 32'h0000_0001);
      rd(REG_CTRL, v);
      check("launch held", {31'h0, v[CTRL_LAUNCH_BIT]}, 32'h1);
      check("reset drive", {31'h0, pin_oe}, 32'h1);
      wait_launch_clear();
      check("presence", {31'h0, v[CTRL_PD_BIT]}, {31'h0, pres});
      $display("test bus_reset done");
   endtask
   task automatic t_byte(input logic [7:0] tx, input logic [7:0] slv, input logic [7:0] rx);
      present <= 1'b1;
      send_byte <= slv;
      n0 = nbytes;
      wr(REG_DATA, {24'h0, tx});
      repeat (700) @(posedge sys_clk_i);
      check("bytes seen", {16'h0, nbytes - n0}, 32'h1);
      check("slave got", {24'h0, got_byte}, {24'h0, tx & slv});
      rd(REG_DATA, v);
      check("rx byte", v, {24'h0, rx});
      $display("test byte done");
   endtask
   task automatic t_buffer_full();
      send_byte <= 8'hFF;
      n0 = nbytes;
      wr(REG_DATA, 32'h0000_0011);
      repeat (5) @(posedge sys_clk_i);
      wr(REG_DATA, 32'h0000_0022);
      wr(REG_DATA, 32'h0000_0033);
      rd(REG_CFG, v);
      check("buffer full", {31'h0, v[CFG_TXFULL_BIT]}, 32'h1);
      wr(REG_DATA, 32'h0000_0044);
      repeat (2100) @(posedge sys_clk_i);
      check("queued bytes", {16'h0, nbytes - n0}, 32'h3);
      rd(REG_DATA, v);
      check("last rx", v, 32'h0000_0033);
      $display("test buffer_full done");
   endtask
   task automatic t_search_byte(input logic [7:0] tx, input logic [7:0] slv, input logic [7:0] rx);
      send_byte <= slv;
      wr(REG_CTRL, 32'h0000_0002);
      n0 = nbytes;
      wr(REG_DATA, {24'h0, tx});
      repeat (1700) @(posedge sys_clk_i);
      check("triplet slots", {16'h0, nbytes - n0}, 32'h3);
      rd(REG_DATA, v);
      check("search dirs", v, {24'h0, rx});
      wr(REG_CTRL, 32'h0000_0000);
      $display("test search_byte done");
   endtask
   initial begin
      resetn_i = 1'b0;
      reg_we_i = 1'b0;
      reg_re_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0000_0000;
      present = 1'b1;
      send_byte = 8'hFF;
      repeat (12) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      t_reset_values();
      t_bit_bang();
      t_search_bit();
      wr(REG_DIV, 32'h0000_0001);
      t_bus_reset(1'b1);
      t_bus_reset(1'b0);
      t_byte(8'hA5, 8'hFF, 8'hA5);
      t_byte(8'hFF, 8'h3C, 8'h3C);
      t_buffer_full();
      t_search_byte(8'hFF, 8'hFF, 8'hFF);
      t_search_byte(8'hA5, 8'h00, 8'hA5);
      t_search_byte(8'h00, 8'h55, 8'h55);
      stop_test();
   end
endmodule // tb_single_wire_master_ctrl_data
`default_nettype wire
